/* alu_flags_defines.vh */
// Constants for the ALU status flag block: register offset, field positions,
// reset values, operation codes and pointer mode codes.
// Assumes inclusion by bare name from the design files; definitions only.
//
// How it works
// - One register: pointer modes, overflow, zero, carries
// - Flag register writable by any instruction
// - Flag-affecting write masks zero, digit carry, carry
// - Clear-file gives 0000u1uu in flag register
// - Subtraction carries are inverted borrows: set when there is no borrow
// - Overflow when signed result leaves -128..+127
// - Operands: working register, file register, immediate
// - Subtract adds two's complement, carry from sum
// - Rotate through carry loads end bit
`ifndef ALU_FLAGS_DEFINES_VH
`define ALU_FLAGS_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ALU_FLAGS_ADDR 8'h04
`define ALU_FLAGS_RESET 8'hf0

// ****************************************************************
// Field positions
// ****************************************************************
`define FLD_CARRY 0
`define FLD_DIGIT_CARRY 1
`define FLD_ZERO 2
`define FLD_OVERFLOW 3
`define FLD_PTR0_LO 4
`define FLD_PTR0_HI 5
`define FLD_PTR1_LO 6
`define FLD_PTR1_HI 7

// ****************************************************************
// Operation codes
// ****************************************************************
`define OP_MOVE 4'h0
`define OP_ADD 4'h1
`define OP_ADD_CARRY 4'h2
`define OP_SUB 4'h3
`define OP_SUB_BORROW 4'h4
`define OP_AND 4'h5
`define OP_OR 4'h6
`define OP_XOR 4'h7
`define OP_CLEAR 4'h8
`define OP_ROT_LEFT_C 4'h9
`define OP_ROT_RIGHT_C 4'ha
`define OP_SWAP 4'hb
`define OP_BIT_CLEAR 4'hc
`define OP_BIT_SET 4'hd
`define OP_INC 4'he
`define OP_DEC 4'hf

// ****************************************************************
// Pointer mode codes
// ****************************************************************
`define PTR_MODE_DEC 2'h0
`define PTR_MODE_INC 2'h1

`endif

/* pointer_stepper.v */
// One indirect pointer and its post-access step.
// Assumes the access strobe is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "alu_flags_defines.vh"

module pointer_stepper (
  input wire core_clk,
  input wire rst_b,
  input wire [1:0] mode,
  input wire access,
  input wire load,
  input wire [7:0] load_data,
  output reg [7:0] ptr_q
);

  // ****************************************************************
  // Pointer register
  // ****************************************************************
  // Load wins over the step; software setting a pointer expects its value
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= 8'h00;
    end else if (load) begin
      ptr_q <= load_data;
    end else if (access) begin
      case (mode)
        `PTR_MODE_DEC: ptr_q <= ptr_q - 8'h01;
        `PTR_MODE_INC: ptr_q <= ptr_q + 8'h01;
        default: ptr_q <= ptr_q;
      endcase
    end
  end

endmodule // pointer_stepper
`default_nettype wire

/* alu_status_flags.v */
// ALU datapath with its flag register and two indirect pointers.
// Assumes one instruction per core_clk, and file accesses decoded upstream:
// file_wr_en with file_addr names the destination of the result.
`timescale 1ns/1ps
`default_nettype none
`include "alu_flags_defines.vh"

module alu_status_flags (
  input wire core_clk,
  input wire rst_b,
  input wire exec,
  input wire [3:0] op,
  input wire use_literal,
  input wire [7:0] working_register,
  input wire [7:0] file_operand,
  input wire [7:0] literal,
  input wire single_on_working,
  input wire [2:0] bit_sel,
  input wire file_wr_en,
  input wire [7:0] file_addr,
  input wire ptr0_access,
  input wire ptr1_access,
  input wire ptr0_load,
  input wire ptr1_load,
  output reg [7:0] result_q,
  output wire [7:0] alu_flags_register,
  output wire [7:0] indirect_pointer_0,
  output wire [7:0] indirect_pointer_1
);

  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg [7:0] res;
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] a_op;
  reg [7:0] b_op;
  reg [7:0] b_add;
  reg cin;
  reg arith;
  reg sets_zero;
  reg sets_carries;
  reg sets_ov;
  reg rot;
  reg new_c;
  reg new_dc;
  reg new_ov;
  wire to_flags;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Signed overflow of an 8-bit add, outside -128..+127
  function ovf;
    input [7:0] x;
    input [7:0] y;
    input [7:0] s;
    begin
      ovf = (x[7] == y[7]) && (s[7] != x[7]);
    end
  endfunction

  assign to_flags = exec && file_wr_en && (file_addr == `ALU_FLAGS_ADDR);

  // ****************************************************************
  // Operand selection and ALU
  // ****************************************************************
  // Two-operand ops pair the working register with a file or literal
  always @* begin
    a_op = working_register;
    b_op = use_literal ? literal : file_operand;
    if (single_on_working) begin
      b_op = working_register;
    end
    b_add = b_op;
    cin = 1'b0;
    arith = 1'b0;
    rot = 1'b0;
    new_c = flags_q[`FLD_CARRY];
    res = b_op;
    sets_zero = 1'b0;
    sets_carries = 1'b0;
    sets_ov = 1'b0;
    case (op)
      `OP_ADD: begin
        arith = 1'b1;
      end
      `OP_ADD_CARRY: begin
        arith = 1'b1;
        cin = flags_q[`FLD_CARRY];
      end
      `OP_SUB: begin
        // Operand minus working register via two's complement
        a_op = b_op;
        b_add = ~working_register;
        cin = 1'b1;
        arith = 1'b1;
      end
      `OP_SUB_BORROW: begin
        a_op = b_op;
        b_add = ~working_register;
        cin = flags_q[`FLD_CARRY];
        arith = 1'b1;
      end
      `OP_INC: begin
        a_op = b_op;
        b_add = 8'h01;
        arith = 1'b1;
      end
      `OP_DEC: begin
        a_op = b_op;
        b_add = 8'hff;
        arith = 1'b1;
      end
      `OP_AND: begin
        res = working_register & b_op;
        sets_zero = 1'b1;
      end
      `OP_OR: begin
        res = working_register | b_op;
        sets_zero = 1'b1;
      end
      `OP_XOR: begin
        res = working_register ^ b_op;
        sets_zero = 1'b1;
      end
      `OP_CLEAR: begin
        res = 8'h00;
        sets_zero = 1'b1;
      end
      `OP_ROT_LEFT_C: begin
        res = {b_op[6:0], flags_q[`FLD_CARRY]};
        new_c = b_op[7];
        rot = 1'b1;
      end
      `OP_ROT_RIGHT_C: begin
        res = {flags_q[`FLD_CARRY], b_op[7:1]};
        new_c = b_op[0];
        rot = 1'b1;
      end
      `OP_SWAP: begin
        res = {b_op[3:0], b_op[7:4]};
      end
      `OP_BIT_CLEAR: begin
        res = b_op & ~(8'h01 << bit_sel);
      end
      `OP_BIT_SET: begin
        res = b_op | (8'h01 << bit_sel);
      end
      default: begin
        res = b_op;
      end
    endcase
    // One adder serves add, subtract, increment and decrement
    sum = {1'b0, a_op} + {1'b0, b_add} + {8'h00, cin};
    nib = {1'b0, a_op[3:0]} + {1'b0, b_add[3:0]} + {4'h0, cin};
    new_dc = nib[4];
    new_ov = ovf(a_op, b_add, sum[7:0]);
    if (arith) begin
      res = sum[7:0];
      new_c = sum[8];
      sets_zero = 1'b1;
      sets_carries = 1'b1;
      sets_ov = 1'b1;
    end
  end

  // ****************************************************************
  // Flag register next value
  // ****************************************************************
  // Written value first, then flags from the outcome override it
  always @* begin
    flags_d = flags_q;
    if (to_flags) begin
      flags_d = res;
      // Any op owning Z, DC or C blocks the write to all three
      if (sets_zero || sets_carries || rot) begin
        flags_d[`FLD_ZERO] = flags_q[`FLD_ZERO];
        flags_d[`FLD_DIGIT_CARRY] = flags_q[`FLD_DIGIT_CARRY];
        flags_d[`FLD_CARRY] = flags_q[`FLD_CARRY];
      end
      if (op == `OP_CLEAR) begin
        flags_d[`FLD_OVERFLOW] = flags_q[`FLD_OVERFLOW];
      end
    end
    if (exec) begin
      if (sets_zero) begin
        flags_d[`FLD_ZERO] = (res == 8'h00);
      end
      if (sets_carries) begin
        flags_d[`FLD_CARRY] = new_c;
        flags_d[`FLD_DIGIT_CARRY] = new_dc;
      end
      if (rot) begin
        flags_d[`FLD_CARRY] = new_c;
      end
      if (sets_ov) begin
        flags_d[`FLD_OVERFLOW] = new_ov;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Flag register holds modes and arithmetic status together
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= `ALU_FLAGS_RESET;
      result_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
      if (exec) begin
        result_q <= res;
      end
    end
  end

  assign alu_flags_register = flags_q;

  // ****************************************************************
  // Indirect pointers
  // ****************************************************************
  // Each pointer steps by its own 2-bit mode field
  pointer_stepper u_ptr0 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mode(flags_q[`FLD_PTR0_HI:`FLD_PTR0_LO]),
    .access(ptr0_access),
    .load(ptr0_load),
    .load_data(res),
    .ptr_q(indirect_pointer_0)
  );

  pointer_stepper u_ptr1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mode(flags_q[`FLD_PTR1_HI:`FLD_PTR1_LO]),
    .access(ptr1_access),
    .load(ptr1_load),
    .load_data(res),
    .ptr_q(indirect_pointer_1)
  );

endmodule // alu_status_flags
`default_nettype wire

/* alu_flags_chk.sv */
// Assertions on the ALU flag block ports.
// Assumes the defines header on the include path; bound below.
`timescale 1ns/1ps
`default_nettype none
`include "alu_flags_defines.vh"
// ********************
// Flag checker
// ********************
module alu_flags_chk (
  input wire core_clk,
  input wire rst_b,
  input wire exec,
  input wire [3:0] op,
  input wire use_literal,
  input wire single_on_working,
  input wire [7:0] working_register,
  input wire [7:0] file_operand,
  input wire file_wr_en,
  input wire [7:0] file_addr,
  input wire ptr0_access,
  input wire ptr1_access,
  input wire ptr0_load,
  input wire ptr1_load,
  input wire [7:0] result_q,
  input wire [7:0] alu_flags_register,
  input wire [7:0] indirect_pointer_0,
  input wire [7:0] indirect_pointer_1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // File operand views; literal and working-register operands are left out
  wire [8:0] sum = {1'b0, working_register} + {1'b0, file_operand};
  wire [8:0] dif = {1'b0, file_operand} + {1'b0, ~working_register} + 9'h001;
  wire ov_add = (working_register[7] == file_operand[7]) && (sum[7] != file_operand[7]);
  wire to_flags = file_wr_en && (file_addr == `ALU_FLAGS_ADDR);
  wire f_file = exec && !use_literal && !single_on_working;
  wire f_add = f_file && (op == `OP_ADD);
  // The overflow check skips flag writes, though the add's own overflow overrides the written bit there
  a_add_carry: assert property (f_add |=> alu_flags_register[0] == $past(sum[8]))
    else $error("add carry wrong");
  a_add_ovf: assert property (f_add && !to_flags |=> alu_flags_register[3] == $past(ov_add))
    else $error("overflow wrong");
  a_sub_borrow: assert property (f_file && op == `OP_SUB |=> alu_flags_register[0] == $past(dif[8]))
    else $error("borrow wrong");
  a_zero_and: assert property (exec && op == `OP_AND |=> alu_flags_register[2] == (result_q == 8'h00))
    else $error("zero wrong");
  a_clear_flags: assert property (exec && op == `OP_CLEAR && to_flags |=>
    alu_flags_register == {4'h0, $past(alu_flags_register[3]), 1'b1, $past(alu_flags_register[1:0])})
    else $error("clear wrong");
  a_rot_left: assert property (f_file && op == `OP_ROT_LEFT_C |=> alu_flags_register[0] == $past(file_operand[7]))
    else $error("rotate left carry wrong");
  a_rot_right: assert property (f_file && op == `OP_ROT_RIGHT_C |=> alu_flags_register[0] == $past(file_operand[0]))
    else $error("rotate right carry wrong");
  a_ptr_inc: assert property (ptr0_access && !ptr0_load && alu_flags_register[5:4] == `PTR_MODE_INC |=>
    indirect_pointer_0 == $past(indirect_pointer_0) + 8'h01) else $error("inc wrong");
  a_ptr_hold: assert property (ptr1_access && !ptr1_load && alu_flags_register[7] |=> $stable(indirect_pointer_1))
    else $error("hold wrong");
  // Rotate into the flag register must not write zero or digit carry
  a_rot_keeps: assert property (exec && to_flags && (op == `OP_ROT_LEFT_C || op == `OP_ROT_RIGHT_C) |=>
    alu_flags_register[2:1] == $past(alu_flags_register[2:1])) else $error("rotate wrote zero or digit carry");
  a_ptr_dec: assert property (ptr0_access && !ptr0_load && alu_flags_register[5:4] == `PTR_MODE_DEC |=>
    indirect_pointer_0 == $past(indirect_pointer_0) - 8'h01) else $error("dec wrong");
endmodule // alu_flags_chk
bind alu_status_flags alu_flags_chk u_chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .exec(exec),
  .op(op),
  .use_literal(use_literal),
  .single_on_working(single_on_working),
  .working_register(working_register),
  .file_operand(file_operand),
  .file_wr_en(file_wr_en),
  .file_addr(file_addr),
  .ptr0_access(ptr0_access),
  .ptr1_access(ptr1_access),
  .ptr0_load(ptr0_load),
  .ptr1_load(ptr1_load),
  .result_q(result_q),
  .alu_flags_register(alu_flags_register),
  .indirect_pointer_0(indirect_pointer_0),
  .indirect_pointer_1(indirect_pointer_1)
);
`default_nettype wire

/* tb.sv */
// Self-checking bench for the ALU flag block.
// Assumes design, header and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "alu_flags_defines.vh"
// ********************
// Bench
// ********************
module tb;
  logic core_clk, rst_b, exec, use_literal, single_on_working, file_wr_en;
  logic ptr0_access, ptr1_access, ptr0_load, ptr1_load;
  logic [3:0] op;
  logic [2:0] bit_sel;
  logic [7:0] working_register, file_operand, literal, file_addr;
  wire [7:0] result_q, alu_flags_register, indirect_pointer_0, indirect_pointer_1;
  int miscompares = 0;
  int checks_done = 0;
  alu_status_flags DUT (.*);
  // Free-running 8 ns clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One instruction; fb feeds the flags back as file operand
  task automatic run(input logic [3:0] o, input logic [7:0] w, f, input logic wr, fb);
    @(posedge core_clk);
    #1;
    exec = 1'b1;
    op = o;
    working_register = w;
    file_operand = fb ? alu_flags_register : f;
    file_wr_en = wr;
    file_addr = wr ? `ALU_FLAGS_ADDR : 8'h10;
    @(posedge core_clk);
    #1;
    exec = 1'b0;
    file_wr_en = 1'b0;
  endtask
  // One indirect access on pointer n
  task automatic step(input logic n);
    @(posedge core_clk);
    #1;
    ptr0_access = !n;
    ptr1_access = n;
    @(posedge core_clk);
    #1;
    ptr0_access = 1'b0;
    ptr1_access = 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    miscompares++;
    complete_run;
  end
  initial begin
    {rst_b, exec, use_literal, single_on_working, file_wr_en, ptr0_access, ptr1_access} = 7'h00;
    {ptr0_load, ptr1_load, op, bit_sel} = 9'h000;
    {working_register, file_operand, literal, file_addr} = 32'h0;
    repeat (6) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk(alu_flags_register, `ALU_FLAGS_RESET);
    chk(indirect_pointer_0, 8'h00);
    run(`OP_ADD, 8'h7f, 8'h01, 1'b0, 1'b0);
    chk(result_q, 8'h80);
    chk(alu_flags_register, 8'hfa);
    run(`OP_SUB, 8'h06, 8'h05, 1'b0, 1'b0);
    chk(result_q, 8'hff);
    chk(alu_flags_register, 8'hf0);
    run(`OP_SUB, 8'h05, 8'h06, 1'b0, 1'b0);
    chk(alu_flags_register, 8'hf3);
    literal = 8'h80;
    use_literal = 1'b1;
    run(`OP_ADD, 8'h80, 8'h00, 1'b0, 1'b0);
    use_literal = 1'b0;
    chk(result_q, 8'h00);
    chk(alu_flags_register, 8'hfd);
    $display("test arithmetic done");
    bit_sel = 3'h7;
    run(`OP_BIT_CLEAR, 8'h00, 8'h00, 1'b1, 1'b1);
    chk(alu_flags_register, 8'h7d);
    run(`OP_CLEAR, 8'h00, 8'h00, 1'b1, 1'b1);
    chk(alu_flags_register, 8'h0d);
    step(1'b0);
    chk(indirect_pointer_0, 8'hff);
    run(`OP_ADD, 8'h01, 8'h54, 1'b1, 1'b0);
    chk(alu_flags_register, 8'h50);
    step(1'b0);
    step(1'b1);
    chk(indirect_pointer_0, 8'h00);
    chk(indirect_pointer_1, 8'h01);
    run(`OP_BIT_SET, 8'h00, 8'h00, 1'b1, 1'b1);
    step(1'b1);
    chk(indirect_pointer_1, 8'h01);
    $display("test flag writes done");
    run(`OP_ROT_RIGHT_C, 8'h00, 8'h01, 1'b0, 1'b0);
    chk(result_q, 8'h00);
    chk(alu_flags_register, 8'hd1);
    run(`OP_ROT_LEFT_C, 8'h00, 8'h7f, 1'b0, 1'b0);
    chk(result_q, 8'hff);
    chk(alu_flags_register, 8'hd0);
    run(`OP_AND, 8'h0f, 8'hf0, 1'b0, 1'b0);
    chk(alu_flags_register, 8'hd4);
    $display("test rotate done");
    run(`OP_ROT_LEFT_C, 8'h00, 8'h00, 1'b1, 1'b1);
    chk(result_q, 8'ha8);
    chk(alu_flags_register, 8'had);
    run(`OP_ADD_CARRY, 8'h01, 8'hfe, 1'b0, 1'b0);
    chk(result_q, 8'h00);
    chk(alu_flags_register, 8'ha7);
    run(`OP_SUB, 8'h02, 8'h01, 1'b0, 1'b0);
    chk(alu_flags_register, 8'ha0);
    run(`OP_SUB_BORROW, 8'h01, 8'h03, 1'b0, 1'b0);
    chk(result_q, 8'h01);
    chk(alu_flags_register, 8'ha3);
    single_on_working = 1'b1;
    run(`OP_INC, 8'hff, 8'h00, 1'b0, 1'b0);
    single_on_working = 1'b0;
    chk(result_q, 8'h00);
    chk(alu_flags_register, 8'ha7);
    run(`OP_DEC, 8'h00, 8'h80, 1'b0, 1'b0);
    chk(result_q, 8'h7f);
    chk(alu_flags_register, 8'ha9);
    run(`OP_OR, 8'h0f, 8'h30, 1'b0, 1'b0);
    chk(result_q, 8'h3f);
    chk(alu_flags_register, 8'ha9);
    run(`OP_XOR, 8'h5a, 8'h5a, 1'b0, 1'b0);
    chk(alu_flags_register, 8'had);
    run(`OP_SWAP, 8'h00, 8'h00, 1'b1, 1'b1);
    chk(alu_flags_register, 8'hda);
    $display("test other ops done");
    // Move from working register loads both pointers; load beats a step
    @(posedge core_clk);
    #1;
    {exec, single_on_working, ptr0_load, ptr1_load, ptr0_access} = 5'h1f;
    op = `OP_MOVE;
    working_register = 8'h3c;
    @(posedge core_clk);
    #1;
    {exec, single_on_working, ptr0_load, ptr1_load, ptr0_access} = 5'h00;
    chk(result_q, 8'h3c);
    chk(indirect_pointer_0, 8'h3c);
    chk(indirect_pointer_1, 8'h3c);
    chk(alu_flags_register, 8'hda);
    // Mid-run reset brings flags, result and pointers back
    @(posedge core_clk);
    #1;
    rst_b = 1'b0;
    @(posedge core_clk);
    #1;
    chk(alu_flags_register, `ALU_FLAGS_RESET);
    chk(indirect_pointer_1, 8'h00);
    chk(result_q, 8'h00);
    rst_b = 1'b1;
    $display("test move and reset done");
    complete_run;
  end
endmodule // tb
`default_nettype wire
